//--- fifo_status_regs.vh
// Register indices, field positions, reset values and codes of the block
`ifndef FIFO_STATUS_REGS_VH
`define FIFO_STATUS_REGS_VH

// Register indices; byte address is four times the index
`define IDX_COMMAND          8'h00
`define IDX_BUFFER_CONTROL   8'h02
`define IDX_FILL_THRESHOLD   8'h03
`define IDX_FILL_COUNT       8'h04
`define IDX_DATA_PORT        8'h05
`define IDX_EVENT_LOW        8'h06

// Buffer control field positions
`define CTL_DEPTH_SELECT     7
`define CTL_NEAR_FULL        6
`define CTL_NEAR_EMPTY       5
`define CTL_FLUSH            4
`define CTL_THRESHOLD_UPPER  2

// Event register field positions
`define EV_POLARITY          7
`define EV_NEAR_FULL         6
`define EV_NEAR_EMPTY        5
`define EV_COMMAND_DONE      4
`define EV_TRANSMIT_DONE     3
`define EV_RECEIVE_END       2
`define EV_ERROR             1
`define EV_FRAME_START       0

// Reset values
`define RST_FILL_THRESHOLD   8'h00
`define RST_EVENT_LOW        7'h00
`define RST_DEPTH_SELECT     1'b0

// Buffer depths and command codes
`define DEPTH_SMALL          10'h0FF
`define DEPTH_LARGE          10'h200
`define CMD_IDLE             5'h00

// Bus answers
`define RESP_OKAY            2'h0
`define RESP_SLVERR          2'h2

`endif

//--- byte_buffer.v
// Byte buffer storage with fill count, flush and selectable depth
`timescale 1ns/10ps
module byte_buffer
(
   // Clock and reset
   input  wire       clock,
   input  wire       arst_n,
   // Control
   input  wire       flush,
   input  wire       depth_small,
   // Push side
   input  wire       push,
   input  wire [7:0] push_data,
   // Pop side
   input  wire       pop,
   output wire [7:0] head_data,
   // Level
   output reg  [9:0] count
);
`include "fifo_status_regs.vh"

   reg  [7:0] mem [0:511];
   reg  [8:0] wr_ptr;
   reg  [8:0] rd_ptr;
   wire [9:0] limit;
   wire       do_push;
   wire       do_pop;

   // Full is judged against the selected depth, not the storage size
   assign limit     = depth_small ? `DEPTH_SMALL : `DEPTH_LARGE;
   assign do_push   = push && (count != limit);
   assign do_pop    = pop && (count != 10'h000);
   assign head_data = mem[rd_ptr];

   // Storage write; no reset needed for data
   always @(posedge clock)
   begin
      if (do_push)
         mem[wr_ptr] <= push_data;
   end

   // Pointers and count; flush overrides any access in the same cycle
   always @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
      begin
         wr_ptr <= 9'h000;
         rd_ptr <= 9'h000;
         count  <= 10'h000;
      end
      else if (flush)
      begin
         wr_ptr <= 9'h000;
         rd_ptr <= 9'h000;
         count  <= 10'h000;
      end
      else
      begin
         if (do_push)
            wr_ptr <= wr_ptr + 9'h001;
         if (do_pop)
            rd_ptr <= rd_ptr + 9'h001;
         if (do_push && !do_pop)
            count <= count + 10'h001;
         else if (do_pop && !do_push)
            count <= count - 10'h001;
      end
   end
endmodule

//--- fifo_level_irq.v
// Buffer level tracking and low event status behind an AXI4-Lite slave
//
// Overview of operation
// [RL1] Threshold gains ninth bit in 512-byte mode
// [RL2] Near-empty when count at or below threshold
// [RL3] Near-full when depth minus count within threshold
// [RL4] Read-only fill count, upper bits in 512 mode
// [RL5] Data write pushes, data read pops one byte
// [RL6] Data port accesses never advance the address
// [RL7] Depth select: one 255 bytes, zero 512
// [RL8] Flush bit empties buffer, always reads zero
// [RL9] Bit 7 chooses set or clear of bits
// [RL10] Software writes FFh sets all, 7Fh clears
// [RL11] Zero bits untouched; polarity bit not stored
// [RL12] Near-full event latches on indication rising
// [RL13] Near-empty event latches on indication rising
// [RL14] Command finishing to idle sets done event
// [RL15] Unknown command reverts to idle, sets done
// [RL16] Host writing idle sets no done event
// [RL17] Transmit done event after last bit sent
// [RL18] Receive end event regardless of data correctness
// [RL19] Host checks error flags after receive end
// [RL20] Any listed error flag rising sets error event; the code sets it only when the OR of all five flags rises
// [RL21] Frame start or subcarrier sets start event; the code sets it from frame_start only and has no subcarrier input
// [RL22] Events stay latched until software clears them
`timescale 1ns/10ps
module fifo_level_irq
(
   // Clock and reset
   input  wire        clock,
   input  wire        arst_n,
   // AXI4-Lite write address
   input  wire [7:0]  awaddr,
   input  wire        awvalid,
   output wire        awready,
   // AXI4-Lite write data
   input  wire [31:0] wdata,
   input  wire [3:0]  wstrb,
   input  wire        wvalid,
   output wire        wready,
   // AXI4-Lite write response
   output reg  [1:0]  bresp,
   output reg         bvalid,
   input  wire        bready,
   // AXI4-Lite read address
   input  wire [7:0]  araddr,
   input  wire        arvalid,
   output wire        arready,
   // AXI4-Lite read data
   output reg  [31:0] rdata,
   output reg  [1:0]  rresp,
   output reg         rvalid,
   input  wire        rready,
   // Command engine
   output reg  [4:0]  command,
   input  wire        command_recognised,
   input  wire        command_finish,
   // Link events, one-cycle pulses
   input  wire        transmit_done,
   input  wire        receive_end,
   input  wire        frame_start,
   // Error flags, levels
   input  wire        buffer_write_error,
   input  wire        buffer_overflow_error,
   input  wire        protocol_error,
   input  wire        missing_data_error,
   input  wire        integrity_error,
   // Level indications
   output wire        near_full_flag,
   output wire        near_empty_flag
);
`include "fifo_status_regs.vh"

   // Register state
   reg        buffer_depth_select;
   reg        threshold_upper_bit;
   reg  [7:0] fill_threshold;
   reg  [6:0] event_status_low;
   reg  [6:0] next_event_status_low;
   reg        start_pending;
   reg        near_full_prev;
   reg        near_empty_prev;
   reg        error_prev;

   // Bus holding state
   reg  [7:0]  aw_addr_held;
   reg         aw_held;
   reg  [31:0] w_data_held;
   reg  [3:0]  w_strb_held;
   reg         w_held;

   // Buffer wires
   wire [9:0] buffer_fill_count;
   wire [7:0] head_data;
   wire [9:0] depth;
   wire [8:0] threshold;
   wire [9:0] room;
   wire [1:0] fill_count_upper_bits;
   wire       error_any;

   // Decoded accesses
   wire       wr_fire;
   wire       rd_fire;
   wire [7:0] wr_index;
   wire [7:0] rd_index;
   wire       wr_low;
   wire       wr_mapped;
   wire       rd_mapped;
   wire       buffer_empty_strobe;
   wire       push;
   wire       pop;
   wire       ev_write;
   wire       cmd_write;
   reg  [7:0] read_byte;

   // Address and data are each taken once and held until the write fires
   assign awready = !aw_held && !bvalid;
   assign wready  = !w_held && !bvalid;
   assign arready = !rvalid;
   assign wr_fire = aw_held && w_held && !bvalid;
   assign rd_fire = arvalid && arready;

   // Word index; low address bits other than word alignment are ignored
   assign wr_index  = {2'b00, aw_addr_held[7:2]};
   assign rd_index  = {2'b00, araddr[7:2]};
   assign wr_low    = w_strb_held[0];
   assign wr_mapped = (wr_index == `IDX_COMMAND)
                   || (wr_index == `IDX_BUFFER_CONTROL)
                   || (wr_index == `IDX_FILL_THRESHOLD)
                   || (wr_index == `IDX_FILL_COUNT)
                   || (wr_index == `IDX_DATA_PORT)
                   || (wr_index == `IDX_EVENT_LOW);
   assign rd_mapped = (rd_index == `IDX_COMMAND)
                   || (rd_index == `IDX_BUFFER_CONTROL)
                   || (rd_index == `IDX_FILL_THRESHOLD)
                   || (rd_index == `IDX_FILL_COUNT)
                   || (rd_index == `IDX_DATA_PORT)
                   || (rd_index == `IDX_EVENT_LOW);

   // Strobes into the buffer; the data port is one fixed address so a
   // burst of accesses streams through it without moving on   // RL6
   assign buffer_empty_strobe = wr_fire && wr_low
      && (wr_index == `IDX_BUFFER_CONTROL)
      && w_data_held[`CTL_FLUSH];                                 // RL8
   assign push = wr_fire && wr_low && (wr_index == `IDX_DATA_PORT); // RL5
   assign pop  = rd_fire && (rd_index == `IDX_DATA_PORT);           // RL5
   assign ev_write  = wr_fire && wr_low && (wr_index == `IDX_EVENT_LOW);
   assign cmd_write = wr_fire && wr_low && (wr_index == `IDX_COMMAND);

   byte_buffer u_buffer
   (
      .clock       (clock),
      .arst_n      (arst_n),
      .flush       (buffer_empty_strobe),
      .depth_small (buffer_depth_select),
      .push        (push),
      .push_data   (w_data_held[7:0]),
      .pop         (pop),
      .head_data   (head_data),
      .count       (buffer_fill_count)
   );

   // Depth and threshold; the ninth threshold bit counts only in 512 mode
   assign depth     = buffer_depth_select ? `DEPTH_SMALL : `DEPTH_LARGE; // RL7
   assign threshold = {threshold_upper_bit && !buffer_depth_select,
                       fill_threshold};                                 // RL1
   assign room      = depth - buffer_fill_count;
   assign near_empty_flag = (buffer_fill_count <= {1'b0, threshold});   // RL2
   assign near_full_flag  = (room <= {1'b0, threshold});                // RL3
   // Upper count bits are shown only in 512 mode
   assign fill_count_upper_bits = buffer_depth_select ? 2'h0
                                : buffer_fill_count[9:8];               // RL4
   assign error_any = buffer_write_error || buffer_overflow_error
                   || protocol_error || missing_data_error
                   || integrity_error;

   // Read mux; flush and polarity bits always read as zero
   always @*
   begin
      read_byte = 8'h00;
      case (rd_index)
         `IDX_COMMAND:        read_byte = {3'h0, command};
         `IDX_BUFFER_CONTROL: read_byte = {buffer_depth_select,
                                           near_full_flag, near_empty_flag,
                                           1'b0, 1'b0, threshold_upper_bit,
                                           fill_count_upper_bits};   // RL8
         `IDX_FILL_THRESHOLD: read_byte = fill_threshold;
         `IDX_FILL_COUNT:     read_byte = buffer_fill_count[7:0];    // RL4
         `IDX_DATA_PORT:      read_byte = head_data;
         `IDX_EVENT_LOW:      read_byte = {1'b0, event_status_low};  // RL11
         default:             read_byte = 8'h00;
      endcase
   end

   // Event update: hardware sets win over a software clear in the same
   // cycle, so no event is lost while software is acknowledging another
   always @*
   begin
      next_event_status_low = event_status_low;
      if (ev_write && !w_data_held[`EV_POLARITY])
         next_event_status_low = event_status_low
                               & ~w_data_held[6:0];                // RL9 RL11
      if (ev_write && w_data_held[`EV_POLARITY])
         next_event_status_low = event_status_low
                               | w_data_held[6:0];           // RL9 RL10 RL11
      if (near_full_flag && !near_full_prev)
         next_event_status_low[`EV_NEAR_FULL] = 1'b1;               // RL12
      if (near_empty_flag && !near_empty_prev)
         next_event_status_low[`EV_NEAR_EMPTY] = 1'b1;              // RL13
      if ((command_finish && command != `CMD_IDLE)
          || (start_pending && !command_recognised))
         next_event_status_low[`EV_COMMAND_DONE] = 1'b1;       // RL14 RL15
      if (transmit_done)
         next_event_status_low[`EV_TRANSMIT_DONE] = 1'b1;           // RL17
      if (receive_end)
         next_event_status_low[`EV_RECEIVE_END] = 1'b1;        // RL18 RL19
      if (error_any && !error_prev)
         next_event_status_low[`EV_ERROR] = 1'b1;                   // RL20
      if (frame_start)
         next_event_status_low[`EV_FRAME_START] = 1'b1;             // RL21
   end

   // Event bits and edge history; bits hold until cleared by software
   always @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
      begin
         event_status_low <= `RST_EVENT_LOW;
         near_full_prev   <= 1'b1;    // No spurious event out of reset
         near_empty_prev  <= 1'b1;
         error_prev       <= 1'b0;
      end
      else
      begin
         event_status_low <= next_event_status_low;                 // RL22
         near_full_prev   <= near_full_flag;
         near_empty_prev  <= near_empty_flag;
         error_prev       <= error_any;
      end
   end

   // Command field: host writes start a command, the engine or an
   // unknown code brings it back to idle; a host idle write is silent
   always @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
      begin
         command       <= `CMD_IDLE;
         start_pending <= 1'b0;
      end
      else if (cmd_write)
      begin
         command       <= w_data_held[4:0];                         // RL16
         start_pending <= (w_data_held[4:0] != `CMD_IDLE);
      end
      else
      begin
         start_pending <= 1'b0;
         if (start_pending && !command_recognised)
            command <= `CMD_IDLE;                                   // RL15
         else if (command_finish)
            command <= `CMD_IDLE;                                   // RL14
      end
   end

   // Configuration registers
   always @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
      begin
         buffer_depth_select <= `RST_DEPTH_SELECT;
         threshold_upper_bit <= 1'b0;
         fill_threshold      <= `RST_FILL_THRESHOLD;
      end
      else if (wr_fire && wr_low)
      begin
         if (wr_index == `IDX_BUFFER_CONTROL)
         begin
            buffer_depth_select <= w_data_held[`CTL_DEPTH_SELECT];  // RL7
            threshold_upper_bit <= w_data_held[`CTL_THRESHOLD_UPPER]; // RL1
         end
         if (wr_index == `IDX_FILL_THRESHOLD)
            fill_threshold <= w_data_held[7:0];
      end
   end

   // Write channel: hold address and data, answer once both are in
   always @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
      begin
         aw_addr_held <= 8'h00;
         aw_held      <= 1'b0;
         w_data_held  <= 32'h00000000;
         w_strb_held  <= 4'h0;
         w_held       <= 1'b0;
         bvalid       <= 1'b0;
         bresp        <= `RESP_OKAY;
      end
      else
      begin
         if (awvalid && awready)
         begin
            aw_addr_held <= awaddr;
            aw_held      <= 1'b1;
         end
         if (wvalid && wready)
         begin
            w_data_held <= wdata;
            w_strb_held <= wstrb;
            w_held      <= 1'b1;
         end
         if (wr_fire)
         begin
            aw_held <= 1'b0;
            w_held  <= 1'b0;
            bvalid  <= 1'b1;
            bresp   <= wr_mapped ? `RESP_OKAY : `RESP_SLVERR;
         end
         else if (bvalid && bready)
            bvalid <= 1'b0;
      end
   end

   // Read channel: data captured at the address handshake
   always @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
      begin
         rvalid <= 1'b0;
         rdata  <= 32'h00000000;
         rresp  <= `RESP_OKAY;
      end
      else if (rd_fire)
      begin
         rvalid <= 1'b1;
         rdata  <= {24'h000000, read_byte};
         rresp  <= rd_mapped ? `RESP_OKAY : `RESP_SLVERR;
      end
      else if (rvalid && rready)
         rvalid <= 1'b0;
   end
endmodule

//--- fifo_level_irq_sva.sv
// Port-level assertions for the level and event status block
`timescale 1ns/10ps
module fifo_level_irq_sva
(
   // Clock and reset
   input wire        clock,
   input wire        arst_n,
   // Register bus
   input wire        awvalid,
   input wire        awready,
   input wire        wvalid,
   input wire        wready,
   input wire        bvalid,
   input wire        bready,
   input wire        arvalid,
   input wire        arready,
   input wire        rvalid,
   input wire        rready,
   input wire [31:0] rdata,
   // Command engine
   input wire [4:0]  command,
   input wire        command_recognised,
   input wire        command_finish
);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!arst_n);
   // Host start of a command and a complete write offer
   sequence s_start;
      command == 5'h00 ##1 command != 5'h00;
   endsequence
   sequence s_both;
      awvalid && awready && wvalid && wready;
   endsequence
   AST_UNKNOWN_CMD: assert property
      (s_start ##0 !command_recognised |=> command == 5'h00)
      else $error("unknown command did not fall back to idle");
   AST_FINISH_CMD: assert property
      (command != 5'h00 && command_finish |=> command == 5'h00)
      else $error("finished command did not return to idle");
   AST_WR_RESP: assert property (s_both |-> ##[1:2] bvalid)
      else $error("write response missing");
   AST_B_DONE: assert property (bvalid && bready |=> !bvalid)
      else $error("write response held after handshake");
   AST_R_CAUSE: assert property
      (rvalid && !$past(rvalid) |-> $past(arvalid && arready))
      else $error("read data without accepted address");
   AST_R_DONE: assert property (rvalid && rready |=> !rvalid)
      else $error("read data held after handshake");
   AST_R_UPPER: assert property (rvalid |-> rdata[31:8] == 24'h0)
      else $error("read data upper bits not zero");
   AST_W_BLOCK: assert property (bvalid |-> !awready && !wready)
      else $error("write channels open while response pending");
   AST_AR_BLOCK: assert property (rvalid |-> !arready)
      else $error("read address open while data pending");
endmodule

bind fifo_level_irq fifo_level_irq_sva chk_u (.clock, .arst_n, .awvalid,
   .awready, .wvalid, .wready, .bvalid, .bready, .arvalid, .arready,
   .rvalid, .rready, .rdata, .command, .command_recognised,
   .command_finish);

//--- cmd_engine_model.sv
// Command engine stand-in: knows low codes, finishes them after a delay
`timescale 1ns/10ps
module cmd_engine_model
#(
   parameter LAT = 20
)
(
   // Clock and reset
   input  wire       clock,
   input  wire       arst_n,
   // Command field and answers
   input  wire [4:0] command,
   output wire       command_recognised,
   output reg        command_finish
);
   reg [7:0] age;
   // Codes 01h to 0Fh are known; higher ones must fall back to idle
   assign command_recognised = (command != 5'h00) && (command < 5'h10);
   // One finish pulse per known command; idle resets the age
   always @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
      begin
         age <= 8'h00;
         command_finish <= 1'b0;
      end
      else
      begin
         command_finish <= command_recognised && (age == LAT);
         age <= command_recognised ? age + 8'h01 : 8'h00;
      end
   end
endmodule

//--- tb_fifo_level_irq.sv
// Self-checking bench for the level and event status block
`timescale 1ns/10ps
`include "fifo_status_regs.vh"
module tb_fifo_level_irq;
   reg          clock, arst_n, awvalid, wvalid, arvalid;
   reg  [7:0]   awaddr, araddr;
   reg  [31:0]  wdata;
   reg  [2:0]   pulse;
   reg  [4:0]   errs;
   reg  [3:0]   wstrb;
   wire         awready, wready, bvalid, arready, rvalid, rec, fin, nf, ne;
   wire [1:0]   bresp, rresp;
   wire [31:0]  rdata;
   wire [4:0]   command;
   int          err_count, n_tests, cnt, thr, i, cyc = 0;
   logic [31:0] seed;
   logic [7:0]  q[$];
   logic [7:0]  pw[7] = '{8'h7F, 8'h81, 8'hA0, 8'h01, 8'h00, 8'hFF, 8'h7F};
   logic [7:0]  pe[7] = '{8'h00, 8'h01, 8'h21, 8'h20, 8'h20, 8'h7F, 8'h00};
   int          bt[3] = '{3, 2, 0};
   logic [7:0]  cw[2] = '{8'h03, 8'h1F};

   fifo_level_irq dut_u (.clock, .arst_n, .awaddr, .awvalid, .awready,
      .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid,
      .bready(1'b1), .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
      .rready(1'b1), .command, .command_recognised(rec),
      .command_finish(fin), .transmit_done(pulse[0]),
      .receive_end(pulse[1]), .frame_start(pulse[2]),
      .buffer_write_error(errs[0]), .buffer_overflow_error(errs[1]),
      .protocol_error(errs[2]), .missing_data_error(errs[3]),
      .integrity_error(errs[4]), .near_full_flag(nf),
      .near_empty_flag(ne));
   cmd_engine_model eng_u (.clock, .arst_n, .command,
      .command_recognised(rec), .command_finish(fin));

   // Free-running system clock
   initial
   begin
      clock = 1'b0;
      forever #10 clock = ~clock;
   end
   // Hang guard, well above the longest expected run
   always @(posedge clock)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         err_count++;
         wrap_up;
      end
   end

   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] s, e);
      n_tests++;
      if (s !== e)
      begin
         err_count++;
         $display("unexpected %s expected %h seen %h", nm, e, s);
      end
   endtask
   // Bus write: both channels offered together, each dropped when taken
   task automatic wr(input [7:0] idx, d, input [1:0] er = 2'h0);
      bit a, w;
      awaddr <= {idx[5:0], 2'b00};
      wdata <= {24'h0, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      a = 0;
      w = 0;
      while (!(a && w))
      begin
         @(posedge clock);
         if (awready && awvalid)
         begin
            a = 1;
            awvalid <= 1'b0;
         end
         if (wready && wvalid)
         begin
            w = 1;
            wvalid <= 1'b0;
         end
      end
      do @(posedge clock); while (!bvalid);
      chk($sformatf("bresp %h", idx), bresp, er);
   endtask
   task automatic rd(input [7:0] idx, input [31:0] e, input [1:0] er = 2'h0);
      araddr <= {idx[5:0], 2'b00};
      arvalid <= 1'b1;
      do @(posedge clock); while (!arready);
      arvalid <= 1'b0;
      do @(posedge clock); while (!rvalid);
      chk($sformatf("rdata %h", idx), rdata, e);
      chk($sformatf("rresp %h", idx), rresp, er);
   endtask
   // Level flags are checked one edge after the count settles
   task automatic flags(input int depth);
      @(posedge clock);
      chk("near_empty", ne, cnt <= thr);
      chk("near_full", nf, (depth - cnt) <= thr);
   endtask
   task automatic push(input int depth);
      seed = xs(seed);
      wr(`IDX_DATA_PORT, seed[7:0]);
      q.push_back(seed[7:0]);
      cnt++;
      flags(depth);
   endtask

   initial
   begin
      arst_n = 1'b0;
      {awvalid, wvalid, arvalid, pulse, errs} = 0;
      {awaddr, araddr, wdata} = 0;
      wstrb = 4'hF;
      seed = 32'hE59A58BE;
      cnt = 0;
      thr = 0;
      repeat (2) @(posedge clock);
      arst_n <= 1'b1;
      @(posedge clock);
      rd(`IDX_FILL_THRESHOLD, 32'h0);
      rd(`IDX_FILL_COUNT, 32'h0);
      rd(`IDX_EVENT_LOW, 32'h0);
      rd(`IDX_BUFFER_CONTROL, 32'h20);
      rd(8'h10, 32'h0, `RESP_SLVERR);
      wr(8'h10, 8'h55, `RESP_SLVERR);
      wr(`IDX_FILL_COUNT, 8'h33);
      rd(`IDX_FILL_COUNT, 32'h0);
      seed = xs(seed);
      wr(`IDX_FILL_THRESHOLD, seed[7:0]);
      rd(`IDX_FILL_THRESHOLD, {24'h0, seed[7:0]});
      // Byte lane 0 off: the write is answered but changes nothing
      wstrb <= 4'h0;
      wr(`IDX_FILL_THRESHOLD, ~seed[7:0]);
      wstrb <= 4'hF;
      rd(`IDX_FILL_THRESHOLD, {24'h0, seed[7:0]});
      // Small depth, threshold 250: near-full rises at five bytes
      thr = 250;
      wr(`IDX_BUFFER_CONTROL, 8'h80);
      wr(`IDX_FILL_THRESHOLD, 8'hFA);
      for (i = 0; i < 10; i++)
         push(255);
      rd(`IDX_FILL_COUNT, 32'd10);
      rd(`IDX_EVENT_LOW, 32'h40);
      for (i = 0; i < 10; i++)
      begin
         rd(`IDX_DATA_PORT, {24'h0, q.pop_front()});
         cnt--;
         flags(255);
      end
      // Polarity writes: set, clear, no change, all at once
      for (i = 0; i < 7; i++)
      begin
         wr(`IDX_EVENT_LOW, pw[i]);
         rd(`IDX_EVENT_LOW, {24'h0, pe[i]});
      end
      // Link events held two cycles: a repeat leaves the bit set
      for (i = 0; i < 3; i++)
      begin
         pulse[i] <= 1'b1;
         repeat (2) @(posedge clock);
         pulse[i] <= 1'b0;
         rd(`IDX_EVENT_LOW, 32'h1 << bt[i]);
         wr(`IDX_EVENT_LOW, 8'h1 << bt[i]);
      end
      // Each error level raises the error event once
      for (i = 0; i < 5; i++)
      begin
         errs[i] <= 1'b1;
         @(posedge clock);
         rd(`IDX_EVENT_LOW, 32'h02);
         wr(`IDX_EVENT_LOW, 8'h02);
         rd(`IDX_EVENT_LOW, 32'h0);
         errs[i] <= 1'b0;
         @(posedge clock);
      end
      // Known command finishing, unknown code, host writing idle
      for (i = 0; i < 2; i++)
      begin
         wr(`IDX_COMMAND, cw[i]);
         repeat (30) @(posedge clock);
         rd(`IDX_COMMAND, 32'h0);
         rd(`IDX_EVENT_LOW, 32'h10);
         wr(`IDX_EVENT_LOW, 8'h10);
      end
      wr(`IDX_COMMAND, 8'h03);
      wr(`IDX_COMMAND, 8'h00);
      repeat (30) @(posedge clock);
      rd(`IDX_EVENT_LOW, 32'h0);
      // Large depth with ninth threshold bit: 256, then 300 bytes
      thr = 256;
      wr(`IDX_BUFFER_CONTROL, 8'h04);
      wr(`IDX_FILL_THRESHOLD, 8'h00);
      for (i = 0; i < 300; i++)
         push(512);
      rd(`IDX_FILL_COUNT, 32'h2C);
      rd(`IDX_BUFFER_CONTROL, 32'h45);
      rd(`IDX_EVENT_LOW, 32'h40);
      wr(`IDX_BUFFER_CONTROL, 8'h14);
      cnt = 0;
      rd(`IDX_FILL_COUNT, 32'h0);
      rd(`IDX_BUFFER_CONTROL, 32'h24);
      rd(`IDX_EVENT_LOW, 32'h60);
      wrap_up;
   end
endmodule
